// [design/fft_bfly.sv]
`timescale 1ns/1ps
`include "fft_defs.svh"

module fft_bfly
#(
   parameter int DW = `FFT_DATA_W
)
(
   input  wire logic [3:0][DW-1:0] inR,
   input  wire logic [3:0][DW-1:0] inI,
   input  wire logic [9:0]         expBase,
   input  wire logic               inverse,
   input  wire logic               extraShift,
   output logic      [3:0][DW-1:0] outR,
   output logic      [3:0][DW-1:0] outI
);

   localparam real PI = 3.14159265358979;
   localparam real FS = (2.0 ** (DW - 1)) - 1.0;
   localparam logic signed [DW:0] POS_MAX = (DW+1)'((2 ** (DW - 1)) - 1);

   logic signed [DW-1:0] sinTab [0:256];
   logic signed [DW+1:0] xR     [4];
   logic signed [DW+1:0] xI     [4];
   logic signed [DW+1:0] sumR   [4];
   logic signed [DW+1:0] sumI   [4];
   logic signed [DW+1:0] dR;
   logic signed [DW+1:0] dI;
   logic signed [DW+1:0] eR;
   logic signed [DW+1:0] eI;

   // quarter-wave sine, built at elaboration: no external table
   genvar k;
   for (k = 0; k <= 256; k++)
   begin : g_tab
      assign sinTab[k] = DW'($rtoi($sin(PI * k / 512.0) * FS + 0.5));
   end

   for (k = 0; k < 4; k++)
   begin : g_ext
      assign xR[k] = {{2{inR[k][DW-1]}}, inR[k]};
      assign xI[k] = {{2{inI[k][DW-1]}}, inI[k]};
   end

   // radix-4 kernel; two extra bits hold the full growth
   assign dR = xR[0] - xR[2];
   assign dI = xI[0] - xI[2];
   assign eR = xR[1] - xR[3];
   assign eI = xI[1] - xI[3];
   assign sumR[0] = xR[0] + xR[1] + xR[2] + xR[3];
   assign sumI[0] = xI[0] + xI[1] + xI[2] + xI[3];
   assign sumR[2] = xR[0] - xR[1] + xR[2] - xR[3];
   assign sumI[2] = xI[0] - xI[1] + xI[2] - xI[3];
   // inverse turns the sense of j round
   assign sumR[1] = inverse ? dR - eI : dR + eI;
   assign sumI[1] = inverse ? dI + eR : dI - eR;
   assign sumR[3] = inverse ? dR + eI : dR - eI;
   assign sumI[3] = inverse ? dI - eR : dI + eR;

   for (k = 0; k < 4; k++)
   begin : g_out
      logic signed [DW+1:0] shR;
      logic signed [DW+1:0] shI;
      logic signed [DW-1:0] yR;
      logic signed [DW-1:0] yI;

      // scaling before the twiddle keeps the product within range
      assign shR = sumR[k] >>> (`FFT_PASS_SHIFT + (extraShift ? 1 : 0));
      assign shI = sumI[k] >>> (`FFT_PASS_SHIFT + (extraShift ? 1 : 0));
      assign yR = shR[DW-1:0];
      assign yI = shI[DW-1:0];

      if (k == 0)
      begin : g_unit
         assign outR[k] = yR;
         assign outI[k] = yI;
      end
      else
      begin : g_rot
         logic [9:0]             ang;
         logic signed [DW-1:0]   s0;
         logic signed [DW-1:0]   c0;
         logic signed [DW-1:0]   wc;
         logic signed [DW-1:0]   ws;
         logic signed [2*DW:0]   pR;
         logic signed [2*DW:0]   pI;
         logic signed [2*DW:0]   qR;
         logic signed [2*DW:0]   qI;

         assign ang = 10'(k * expBase);
         assign s0 = sinTab[{1'b0, ang[7:0]}];
         assign c0 = sinTab[9'h100 - {1'b0, ang[7:0]}];

         always_comb
         begin
            unique case (ang[9:8])
               2'h0:
               begin
                  wc = c0;
                  ws = s0;
               end
               2'h1:
               begin
                  wc = -s0;
                  ws = c0;
               end
               2'h2:
               begin
                  wc = -c0;
                  ws = -s0;
               end
               2'h3:
               begin
                  wc = s0;
                  ws = -c0;
               end
            endcase
         end

         // forward uses e^-j, inverse e^+j
         assign pR = inverse ? yR * wc - yI * ws : yR * wc + yI * ws;
         assign pI = inverse ? yI * wc + yR * ws : yI * wc - yR * ws;
         assign qR = pR >>> (DW - 1);
         assign qI = pI >>> (DW - 1);
         // saturate: a rotated corner may exceed full scale slightly
         assign outR[k] = (qR > POS_MAX) ? POS_MAX[DW-1:0] :
                          (qR < -POS_MAX - 1) ? {1'b1, {(DW-1){1'b0}}} :
                          qR[DW-1:0];
         assign outI[k] = (qI > POS_MAX) ? POS_MAX[DW-1:0] :
                          (qI < -POS_MAX - 1) ? {1'b1, {(DW-1){1'b0}}} :
                          qI[DW-1:0];
      end
   end

endmodule

// [design/fft_defs.svh]
`ifndef FFT_DEFS_SVH
`define FFT_DEFS_SVH

// transform geometry
`define FFT_N               1024
`define FFT_ADDR_W          10
`define FFT_DATA_W          16
`define FFT_STAGES          5
`define FFT_BFLY_PER_STAGE  256
`define FFT_BANKS           3

// reset placement of the three vector banks
`define FFT_LOAD_BANK_RST   2'h0
`define FFT_COMP_BANK_RST   2'h1
`define FFT_OUT_BANK_RST    2'h2

// register offsets (byte addresses)
`define FFT_CTRL_OFS        12'h000
`define FFT_STAT_OFS        12'h004

// control register fields
`define FFT_CTRL_RUN        0
`define FFT_CTRL_MODE_LSB   1
`define FFT_CTRL_RST        32'h0000_0000

// status register fields
`define FFT_STAT_BUSY       0
`define FFT_STAT_FULL       1
`define FFT_STAT_STAGE_LSB  4
`define FFT_STAT_BFLY_LSB   8
`define FFT_STAT_COUNT_LSB  16

// butterfly scaling per pass, in bits
`define FFT_PASS_SHIFT      2

`endif

// [design/fft_engine.sv]
// The address map and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "fft_defs.svh"
// What this block does
// - forward or inverse transform of 1024 samples
// - inputs are 16-bit two's complement pairs
// - outputs are 16-bit two's complement pairs
// - five radix-4 passes of 256 butterflies
// - twiddles made inside, 16-bit precision
// - butterfly results return to their addresses
// - every pass divides results by four
// - scale select adds one shift, first pass
// - overall gain 1/1024 or 1/2048
// - scale select same for both directions
// - inverse uses positive exponent, built-in 1/N
// - natural order in and out
// - loading, transforming, reading may overlap
// - engine drives memory addresses and enables
// - three selectable memory arrangements
// - direction high forward, sampled at start
// - continuous modes resample at mode latch
// - rising edge, clock enable, synchronous reset

module fft_engine
#(
   parameter int DW = `FFT_DATA_W
)
(
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic          ce,
   input  wire logic          start,
   input  wire logic          directionSelect,
   input  wire logic          scaleMode,
   input  wire logic          inputWriteStrobe,
   input  wire logic [DW-1:0] dataInR,
   input  wire logic [DW-1:0] dataInI,
   output logic               inputReady,
   input  wire logic          resultReadStrobe,
   output logic               resultReady,
   output logic               resultValid,
   output logic [DW-1:0]      resultR,
   output logic [DW-1:0]      resultI,
   output logic [9:0]         resultIndex,
   output logic               busy,
   output logic               done,
   output logic               modeLatch,
   input  wire logic          hsel,
   input  wire logic [31:0]   haddr,
   input  wire logic [1:0]    htrans,
   input  wire logic          hwrite,
   input  wire logic [2:0]    hsize,
   input  wire logic [31:0]   hwdata,
   input  wire logic          hready,
   output logic               hreadyout,
   output logic               hresp,
   output logic [31:0]        hrdata
);

   localparam int AW = `FFT_ADDR_W;
   localparam logic [2:0] LAST_STAGE = 3'(`FFT_STAGES - 1);
   localparam logic [7:0] LAST_BFLY  = 8'(`FFT_BFLY_PER_STAGE - 1);

   fft_pkg::fft_state_t  state_r;
   fft_pkg::fft_iomode_t ioMode_r;

   logic [2*DW-1:0]      mem [0:`FFT_BANKS*`FFT_N-1];
   logic [1:0]           loadB_r;
   logic [1:0]           compB_r;
   logic [1:0]           outB_r;
   logic [AW-1:0]        loadIdx_r;
   logic [AW-1:0]        outIdx_r;
   logic                 loadFull_r;
   logic                 run_r;
   logic                 swStart_r;
   logic                 dirLat_r;
   logic                 scaleLat_r;
   logic [2:0]           stage_r;
   logic [7:0]           bfly_r;
   logic [1:0]           quad_r;
   logic [15:0]          count_r;
   logic [3:0][DW-1:0]   aR_r;
   logic [3:0][DW-1:0]   aI_r;
   logic [3:0][DW-1:0]   yR;
   logic [3:0][DW-1:0]   yI;
   logic [DW-1:0]        resultR_r;
   logic [DW-1:0]        resultI_r;
   logic [AW-1:0]        resultIndex_r;
   logic                 resultValid_r;
   logic                 done_r;
   logic                 modeLatch_r;
   logic [AW-1:0]        bAddr;
   logic [AW-1:0]        expBase;
   logic [2*DW-1:0]      rdWord;
   logic                 single;
   logic                 startReq;
   logic                 launch;
   logic                 finish;
   logic                 loadWe;
   logic                 rdGo;
   logic                 addrPhase;
   logic                 dpWrite_r;
   logic [11:0]          dpAddr_r;
   logic                 ctrlWr;
   logic [31:0]          ctrlWord;
   logic [31:0]          statWord;
   logic [31:0]          rdMux;
   logic [31:0]          hrdata_r;

   // radix-4 digit reversal undoes the scrambled order of the passes
   function automatic logic [9:0] digitRev(input logic [9:0] i);
      digitRev = {i[1:0], i[3:2], i[5:4], i[7:6], i[9:8]};
   endfunction

   assign single   = (ioMode_r == fft_pkg::FFT_SINGLE);
   assign busy     = (state_r != fft_pkg::FFT_IDLE);
   assign startReq = start | swStart_r;
   // single memory transforms on start; the others run while fed
   assign launch   = ce && !busy &&
                     (single ? startReq : (run_r && loadFull_r));
   assign finish   = ce && (state_r == fft_pkg::FFT_WRITE) &&
                     (quad_r == 2'h3) && (bfly_r == LAST_BFLY) &&
                     (stage_r == LAST_STAGE);

   // loading is refused while the only bank is being transformed
   assign inputReady  = !loadFull_r && !(single && busy);
   assign resultReady = !(single && busy);
   assign loadWe      = ce && inputWriteStrobe && inputReady;
   assign rdGo        = ce && resultReadStrobe && resultReady;

   // butterfly operand address and twiddle step per pass
   always_comb
   begin
      bAddr   = '0;
      expBase = '0;
      unique case (stage_r)
         3'h0:
         begin
            bAddr   = {quad_r, bfly_r};
            expBase = {2'h0, bfly_r};
         end
         3'h1:
         begin
            bAddr   = {bfly_r[7:6], quad_r, bfly_r[5:0]};
            expBase = {2'h0, bfly_r[5:0], 2'h0};
         end
         3'h2:
         begin
            bAddr   = {bfly_r[7:4], quad_r, bfly_r[3:0]};
            expBase = {2'h0, bfly_r[3:0], 4'h0};
         end
         3'h3:
         begin
            bAddr   = {bfly_r[7:2], quad_r, bfly_r[1:0]};
            expBase = {2'h0, bfly_r[1:0], 6'h00};
         end
         3'h4:
         begin
            bAddr   = {bfly_r, quad_r};
            expBase = '0;
         end
         default:
         begin
            bAddr   = '0;
            expBase = '0;
         end
      endcase
   end

   assign rdWord = mem[{compB_r, bAddr}];

   // working storage: one port loads, one runs the butterflies
   always_ff @(posedge clk)
   begin
      if (loadWe)
         mem[{loadB_r, loadIdx_r}] <= {dataInR, dataInI};
      if (ce && state_r == fft_pkg::FFT_WRITE)
         mem[{compB_r, bAddr}] <= {yR[quad_r], yI[quad_r]};
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         state_r <= fft_pkg::FFT_IDLE;
      else if (ce)
      begin
         unique case (state_r)
            fft_pkg::FFT_IDLE:
               if (launch)
                  state_r <= fft_pkg::FFT_READ;
            fft_pkg::FFT_READ:
               if (quad_r == 2'h3)
                  state_r <= fft_pkg::FFT_WRITE;
            fft_pkg::FFT_WRITE:
               if (quad_r == 2'h3)
                  state_r <= finish ? fft_pkg::FFT_IDLE : fft_pkg::FFT_READ;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         quad_r  <= 2'h0;
         bfly_r  <= 8'h00;
         stage_r <= 3'h0;
      end
      else if (launch)
      begin
         quad_r  <= 2'h0;
         bfly_r  <= 8'h00;
         stage_r <= 3'h0;
      end
      else if (ce && busy)
      begin
         quad_r <= quad_r + 2'h1;
         if (state_r == fft_pkg::FFT_WRITE && quad_r == 2'h3)
         begin
            bfly_r <= bfly_r + 8'h01;
            if (bfly_r == LAST_BFLY)
               stage_r <= stage_r + 3'h1;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (ce && state_r == fft_pkg::FFT_READ)
      begin
         aR_r[quad_r] <= rdWord[2*DW-1:DW];
         aI_r[quad_r] <= rdWord[DW-1:0];
      end
   end

   fft_bfly #(.DW(DW)) u_bfly
   (
      .inR        (aR_r),
      .inI        (aI_r),
      .expBase    (expBase),
      .inverse    (!dirLat_r),
      .extraShift (scaleLat_r && stage_r == 3'h0),
      .outR       (yR),
      .outI       (yI)
   );

   // settings are caught once per transform, never mid-flight
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         dirLat_r   <= 1'b1;
         scaleLat_r <= 1'b0;
      end
      else if (launch)
      begin
         dirLat_r   <= directionSelect;
         scaleLat_r <= scaleMode;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         modeLatch_r <= 1'b0;
         done_r      <= 1'b0;
         count_r     <= 16'h0000;
      end
      else
      begin
         modeLatch_r <= launch;
         done_r      <= finish;
         if (finish)
            count_r <= count_r + 16'h0001;
      end
   end

   // bank rotation lets load, transform and read-out overlap
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         loadB_r <= `FFT_LOAD_BANK_RST;
         compB_r <= `FFT_COMP_BANK_RST;
         outB_r  <= `FFT_OUT_BANK_RST;
      end
      else
      begin
         if (launch)
         begin
            compB_r <= loadB_r;
            unique case (ioMode_r)
               fft_pkg::FFT_SINGLE: loadB_r <= loadB_r;
               fft_pkg::FFT_DUAL:   loadB_r <= {1'b0, ~loadB_r[0]};
               fft_pkg::FFT_TRIPLE: loadB_r <= 2'h3 - loadB_r - outB_r;
            endcase
         end
         if (finish)
            outB_r <= compB_r;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         loadIdx_r  <= '0;
         loadFull_r <= 1'b0;
      end
      else
      begin
         if (launch)
            loadFull_r <= 1'b0;
         if (loadWe)
         begin
            loadIdx_r <= loadIdx_r + 10'h001;
            if (loadIdx_r == '1)
               loadFull_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         outIdx_r      <= '0;
         resultValid_r <= 1'b0;
         resultR_r     <= '0;
         resultI_r     <= '0;
         resultIndex_r <= '0;
      end
      else
      begin
         resultValid_r <= rdGo;
         if (rdGo)
         begin
            {resultR_r, resultI_r} <= mem[{outB_r, digitRev(outIdx_r)}];
            resultIndex_r <= outIdx_r;
            outIdx_r      <= outIdx_r + 10'h001;
         end
      end
   end

   assign resultR     = resultR_r;
   assign resultI     = resultI_r;
   assign resultIndex = resultIndex_r;
   assign resultValid = resultValid_r;
   assign done        = done_r;
   assign modeLatch   = modeLatch_r;

   // bus slave: zero wait states, read data caught in the address phase
   assign addrPhase = hsel && hready && htrans[1];
   assign ctrlWr    = dpWrite_r && (dpAddr_r == `FFT_CTRL_OFS);

   always_comb
   begin
      ctrlWord = `FFT_CTRL_RST;
      ctrlWord[`FFT_CTRL_RUN] = run_r;
      ctrlWord[`FFT_CTRL_MODE_LSB +: 2] = ioMode_r;
      statWord = '0;
      statWord[`FFT_STAT_BUSY] = busy;
      statWord[`FFT_STAT_FULL] = loadFull_r;
      statWord[`FFT_STAT_STAGE_LSB +: 3] = stage_r;
      statWord[`FFT_STAT_BFLY_LSB +: 8] = bfly_r;
      statWord[`FFT_STAT_COUNT_LSB +: 16] = count_r;
      case (haddr[11:0])
         `FFT_CTRL_OFS: rdMux = ctrlWord;
         `FFT_STAT_OFS: rdMux = statWord;
         default:       rdMux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         dpWrite_r <= 1'b0;
         dpAddr_r  <= 12'h000;
         hrdata_r  <= 32'h0000_0000;
      end
      else
      begin
         dpWrite_r <= addrPhase && hwrite;
         if (addrPhase)
            dpAddr_r <= haddr[11:0];
         if (addrPhase && !hwrite)
            hrdata_r <= rdMux;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         ioMode_r  <= fft_pkg::FFT_SINGLE;
         run_r     <= 1'b0;
         swStart_r <= 1'b0;
      end
      else
      begin
         // a mode change mid-transform takes effect at once in the stream gating; banks rotate by it at next launch
         if (ctrlWr && hwdata[`FFT_CTRL_MODE_LSB +: 2] != 2'h3)
            ioMode_r <= fft_pkg::fft_iomode_t'(hwdata[`FFT_CTRL_MODE_LSB +: 2]);
         if (ce && startReq)
            run_r <= 1'b1;
         else if (ctrlWr && !hwdata[`FFT_CTRL_RUN])
            run_r <= 1'b0;
         if (ctrlWr && hwdata[`FFT_CTRL_RUN])
            swStart_r <= 1'b1;
         else if (ce)
            swStart_r <= 1'b0;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_r;

endmodule

// [design/fft_pkg.sv]
package fft_pkg;

   typedef enum logic [2:0]
   {
      FFT_IDLE  = 3'b001,
      FFT_READ  = 3'b010,
      FFT_WRITE = 3'b100
   } fft_state_t;

   typedef enum logic [1:0]
   {
      FFT_SINGLE = 2'h0,
      FFT_DUAL   = 2'h1,
      FFT_TRIPLE = 2'h2
   } fft_iomode_t;

endpackage

// [testbench/fft_engine_properties.sv]
`timescale 1ns/1ps
module fft_engine_properties
(
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        ce,
   input wire logic        start,
   input wire logic        resultReadStrobe,
   input wire logic        inputReady,
   input wire logic        resultReady,
   input wire logic        resultValid,
   input wire logic [15:0] resultR,
   input wire logic [15:0] resultI,
   input wire logic [9:0]  resultIndex,
   input wire logic        busy,
   input wire logic        done,
   input wire logic        modeLatch,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata
);
   int unsigned busyCnt;
   logic        rdTaken_r;
   logic [9:0]  nextIdx_r;
   logic        ctlWr_r;
   logic        concur_r;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // cycles spent busy since the launch pulse
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         busyCnt <= 0;
      else if (modeLatch)
         busyCnt <= 1;
      else if (busy)
         busyCnt <= busyCnt + 1;
   end

   always_ff @(posedge clk)
   begin
      rdTaken_r <= rst_n && ce && resultReadStrobe && resultReady;
   end

   // tracks whether software chose a concurrent bank arrangement
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         ctlWr_r  <= 1'b0;
         concur_r <= 1'b0;
      end
      else
      begin
         ctlWr_r <= hsel && hready && htrans[1] && hwrite &&
                    haddr[11:0] == 12'h000;
         if (ctlWr_r && hwdata[2:1] != 2'h3)
            concur_r <= hwdata[2:1] != 2'h0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         nextIdx_r <= 10'h0;
      else if (resultValid)
         nextIdx_r <= resultIndex + 10'h1;
   end

   // start pin is only pulsed in single mode, where it launches alone
   chk_launch_pulse: assert property (
      ce && start && !busy |=> modeLatch && busy)
      else $error("launch did not raise latch and busy");
   chk_done_time: assert property (
      done |-> busyCnt == 10240 && !busy)
      else $error("transform length wrong");
   chk_done_single: assert property (
      done |=> !done && !busy)
      else $error("done longer than one cycle");
   chk_valid_timing: assert property (
      resultValid == rdTaken_r)
      else $error("result valid not one cycle after read");
   chk_index_step: assert property (
      resultValid |-> resultIndex == nextIdx_r)
      else $error("result index out of order");
   chk_result_hold: assert property (
      !resultValid && $past(rst_n) |-> $stable(resultR) && $stable(resultI))
      else $error("result changed without valid");
   chk_busy_block: assert property (
      busy && !concur_r |-> !inputReady && !resultReady)
      else $error("streams open while busy");
   chk_overlap_open: assert property (
      busy && concur_r |-> resultReady)
      else $error("result stream closed in concurrent mode");
   chk_bus_okay: assert property (
      hreadyout && !hresp)
      else $error("bus not ready or not okay");
   chk_bus_unmapped: assert property (
      hsel && hready && htrans[1] && !hwrite && haddr[11:0] > 12'h004
      |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
endmodule

bind fft_engine fft_engine_properties u_chk (.*);

// [testbench/fft_engine_tb.sv]
`timescale 1ns/1ps
`include "fft_defs.svh"
module fft_engine_tb;
   typedef struct packed
   {
      logic        dir;
      logic        scl;
      logic        viaBus;
      logic [15:0] expR;
      logic [15:0] expI;
   } fft_row_t;

   // dc input: bin 0 carries the value over s, all others zero
   // the bus-started row runs with dual banks
   localparam fft_row_t ROWS [4] = '{
      '{1'b1, 1'b0, 1'b0, 16'h0400, 16'hfe00},
      '{1'b1, 1'b1, 1'b0, 16'h0200, 16'hff00},
      '{1'b0, 1'b0, 1'b1, 16'h0400, 16'hfe00},
      '{1'b0, 1'b1, 1'b0, 16'h0200, 16'hff00}};

   logic        clk;
   logic        rst_n = 1'b0;
   logic        ce = 1'b1;
   logic        start = 1'b0;
   logic        dirSel = 1'b0;
   logic        scl = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h0;
   logic        loadGo = 1'b0;
   logic        readGo = 1'b0;
   logic        wrStb, rdStb, inputReady, resultReady, resultValid;
   logic        busy, done, modeLatch, hreadyout, hresp, active;
   logic [15:0] dR, dI, resultR, resultI, expR, expI;
   logic [9:0]  resultIndex;
   logic [31:0] hrdata, rd;
   int          rdIdx, errCount, samplesChecked;
   int          cycles = 0;

   fft_engine u_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .start(start),
      .directionSelect(dirSel), .scaleMode(scl), .inputWriteStrobe(wrStb),
      .dataInR(dR), .dataInI(dI), .inputReady(inputReady),
      .resultReadStrobe(rdStb), .resultReady(resultReady),
      .resultValid(resultValid), .resultR(resultR), .resultI(resultI),
      .resultIndex(resultIndex), .busy(busy), .done(done),
      .modeLatch(modeLatch), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

   fft_user_model u_user (.clk(clk), .loadGo(loadGo), .readGo(readGo),
      .inputReady(inputReady), .resultReady(resultReady), .wrStb(wrStb),
      .rdStb(rdStb), .dR(dR), .dI(dI), .active(active));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
      samplesChecked++;
      if (seen !== exp)
      begin
         errCount++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task close_out();
      $display("checks %0d mismatches %0d", samplesChecked, errCount);
      if (errCount == 0 && samplesChecked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic ahb_xfer(logic wr, logic [11:0] a, logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= 3'h2;
      @(posedge clk);
      while (!hreadyout) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clk);
      while (!hreadyout) @(posedge clk);
      rd = hrdata;
   endtask

   task automatic run_model(logic isRead);
      readGo <= isRead;
      loadGo <= !isRead;
      @(posedge clk);
      readGo <= 1'b0;
      loadGo <= 1'b0;
      @(posedge clk);
      while (active) @(posedge clk);
      // let the last result pulse reach the monitor
      repeat (2) @(posedge clk);
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         errCount++;
         close_out();
      end
   end

   always @(posedge clk)
   begin
      if (resultValid === 1'b1)
      begin
         check("index", resultIndex, rdIdx[9:0]);
         check("re", resultR, rdIdx == 0 ? expR : 16'h0);
         check("im", resultI, rdIdx == 0 ? expI : 16'h0);
         rdIdx++;
      end
   end

   initial
   begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      check("busy", busy, 0);
      check("inready", inputReady, 1);
      check("resready", resultReady, 1);
      ahb_xfer(1'b0, `FFT_CTRL_OFS, 32'h0);
      check("ctrl", rd, 0);
      ahb_xfer(1'b1, 12'h010, 32'hffffffff);
      ahb_xfer(1'b0, 12'h010, 32'h0);
      check("unmapped", rd, 0);
      for (int i = 0; i < 4; i++)
      begin
         expR = ROWS[i].expR;
         expI = ROWS[i].expI;
         run_model(1'b0);
         check("inready full", inputReady, 0);
         ahb_xfer(1'b0, `FFT_STAT_OFS, 32'h0);
         check("full", 32'(rd[1]), 1);
         dirSel <= ROWS[i].dir;
         scl <= ROWS[i].scl;
         if (ROWS[i].viaBus)
            ahb_xfer(1'b1, `FFT_CTRL_OFS, 32'h3);
         else
         begin
            start <= 1'b1;
            @(posedge clk);
            start <= 1'b0;
         end
         while (!busy) @(posedge clk);
         // flipped settings must not reach the running transform
         dirSel <= ~ROWS[i].dir;
         scl <= ~ROWS[i].scl;
         while (busy) @(posedge clk);
         if (ROWS[i].viaBus)
         begin
            ahb_xfer(1'b0, `FFT_CTRL_OFS, 32'h0);
            check("run", 32'(rd[0]), 1);
            check("mode", 32'(rd[2:1]), 1);
            ahb_xfer(1'b1, `FFT_CTRL_OFS, 32'h0);
         end
         rdIdx = 0;
         run_model(1'b1);
         check("count", rdIdx, 1024);
      end
      ahb_xfer(1'b0, `FFT_STAT_OFS, 32'h0);
      check("done count", 32'(rd[31:16]), 4);
      run_model(1'b0);
      ce <= 1'b0;
      start <= 1'b1;
      repeat (3) @(posedge clk);
      check("ce gate", busy, 0);
      ce <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      @(posedge clk);
      check("ce launch", busy, 1);
      rst_n <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      check("reset busy", busy, 0);
      check("reset inready", inputReady, 1);
      close_out();
   end
endmodule

// [testbench/fft_user_model.sv]
`timescale 1ns/1ps
module fft_user_model
#(
   parameter logic [15:0] VAL_R = 16'h0400,
   parameter logic [15:0] VAL_I = 16'hfe00
)
(
   input  wire logic        clk,
   input  wire logic        loadGo,
   input  wire logic        readGo,
   input  wire logic        inputReady,
   input  wire logic        resultReady,
   output logic             wrStb,
   output logic             rdStb,
   output logic [15:0]      dR,
   output logic [15:0]      dI,
   output logic             active
);
   int ldLeft = 0;
   int rdLeft = 0;
   int ldNxt;
   int rdNxt;

   initial
   begin
      wrStb = 1'b0;
      rdStb = 1'b0;
      dR = 16'h0;
      dI = 16'h0;
   end

   assign active = ldLeft != 0 || rdLeft != 0;
   assign ldNxt = loadGo ? 1024 : ldLeft - int'(wrStb && inputReady);
   assign rdNxt = readGo ? 1024 : rdLeft - int'(rdStb && resultReady);

   // strobe held until taken; idle data toggles so stale values never match
   always @(posedge clk)
   begin
      ldLeft <= ldNxt;
      rdLeft <= rdNxt;
      wrStb <= ldNxt > 0;
      rdStb <= rdNxt > 0;
      dR <= ldNxt > 0 ? VAL_R : ~dR;
      dI <= ldNxt > 0 ? VAL_I : ~dI;
   end
endmodule
